// ### verilog/dusw_pkg.sv
// Shared constants and types for the disc unit select and write protect block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and one 20 MHz clock.
package dusw_pkg;

	// Avalon register map, byte offsets
	localparam logic [7:0] DUSW_OFS_CTRL = 8'h00;
	localparam logic [7:0] DUSW_OFS_SWITCH = 8'h04;
	localparam logic [7:0] DUSW_OFS_PROTECT = 8'h08;
	localparam logic [7:0] DUSW_OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] DUSW_OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] DUSW_OFS_LAST_CMD = 8'h14;

	// Reset values
	localparam logic [1:0] DUSW_CTRL_RESET = 2'h1;
	localparam logic [2:0] DUSW_IRQ_MASK_RESET = 3'h0;

	// Control register bits
	localparam int DUSW_CTRL_RESPOND_BIT = 0;
	localparam int DUSW_CTRL_CLR_UNIT_BIT = 1;

	// Interrupt status bits
	localparam int DUSW_IRQ_DONE_BIT = 0;
	localparam int DUSW_IRQ_WPROT_BIT = 1;
	localparam int DUSW_IRQ_REJECT_BIT = 2;

	// Switch register fields
	localparam int DUSW_SW_CTRL_LSB = 0;
	localparam int DUSW_SW_UNIT_LSB = 4;
	localparam int DUSW_SW_ONLINE_BIT = 7;
	localparam int DUSW_SW_BUSY_BIT = 8;
	localparam int DUSW_SW_PEND_BIT = 9;

	// Device geometry, addressing and synchroniser depth
	localparam int DUSW_TRACKS = 512;
	localparam int DUSW_GROUP_TRACKS = 32;
	localparam int DUSW_GROUPS = DUSW_TRACKS / DUSW_GROUP_TRACKS;
	localparam int DUSW_GROUP_LSB = 5;
	localparam logic DUSW_CTRL_ADDR_MSB = 1'b1;
	localparam int DUSW_SYNC_STAGES = 3;

	// Acknowledge word layout
	localparam int DUSW_ACK_STATUS_LSB = 0;
	localparam int DUSW_ACK_UNIT_LSB = 21;
	localparam int DUSW_ACK_CTRL_LSB = 24;

	// Status halfword bits returned to the io_processor
	localparam int DUSW_ST_BUSY = 0;
	localparam int DUSW_ST_PEND = 1;
	localparam int DUSW_ST_ONLINE = 2;
	localparam int DUSW_ST_WPROT = 3;
	localparam int DUSW_ST_ACCEPT = 4;

	typedef enum logic [2:0] {
		DUSW_CMD_NONE = 3'h0,
		DUSW_CMD_START = 3'h1,
		DUSW_CMD_HALT = 3'h2,
		DUSW_CMD_TEST_IO = 3'h3,
		DUSW_CMD_TEST_DEV = 3'h4,
		DUSW_CMD_ACK_INT = 3'h5
	} dusw_cmd_e;

	typedef enum logic [2:0] {
		DUSW_ST_IDLE = 3'b001,
		DUSW_ST_RUN = 3'b010,
		DUSW_ST_PENDING = 3'b100
	} dusw_state_e;

	// Command from the io_processor, valid for one cycle
	typedef struct packed {
		logic valid;
		dusw_cmd_e code;
		logic [3:0] ctrl_addr;
		logic [2:0] unit_addr;
		logic [8:0] track;
		logic write_op;
		logic [15:0] word_count;
	} dusw_cmd_s;

	// Answer to the io_processor, valid for one cycle
	typedef struct packed {
		logic valid;
		logic accepted;
		logic [31:0] data;
	} dusw_resp_s;

endpackage

// ### verilog/dusw_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes inputs are asynchronous switch levels; output changes only when stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module dusw_sync #(
	parameter int W = 1
) (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	// Levels
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	logic [W-1:0] out_next;

	always_comb begin
		out_next = out_reg;
		for (int i = 0; i < W; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				out_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else if (ce) begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule
`default_nettype wire

// ### verilog/dusw_top.sv
// Disc controller address selection, online control, track-group write protection and command answers.
// Assumes switch pins are asynchronous, the io_processor command port and Avalon bus share core_clk.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module dusw_top
	import dusw_pkg::*;
(
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	// Switch pins, high is up
	input wire logic [2:0] ctrl_addr_sw,
	input wire logic [2:0] unit_addr_sw,
	input wire logic online_sw,
	input wire logic [15:0] protect_sw,
	// io_processor command port
	input wire dusw_cmd_s io_cmd,
	output dusw_resp_s io_resp,
	// Priority chain and interrupt toward the io_processor
	input wire logic prio_in,
	output logic prio_out,
	output logic io_interrupt,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Software interrupt
	output logic irq
);
	logic [2:0] ctrl_sw_s, unit_sw_s;
	logic online_s;
	logic [15:0] protect_s;
	logic [3:0] own_ctrl_addr;

	dusw_sync #(.W(3)) u_sync_ctrl (.core_clk(core_clk), .reset(reset), .ce(ce), .din(ctrl_addr_sw),
		.dout(ctrl_sw_s));
	dusw_sync #(.W(3)) u_sync_unit (.core_clk(core_clk), .reset(reset), .ce(ce), .din(unit_addr_sw),
		.dout(unit_sw_s));
	dusw_sync #(.W(1)) u_sync_online (.core_clk(core_clk), .reset(reset), .ce(ce), .din(online_sw),
		.dout(online_s));
	dusw_sync #(.W(16)) u_sync_prot (.core_clk(core_clk), .reset(reset), .ce(ce), .din(protect_sw),
		.dout(protect_s));

	assign own_ctrl_addr = {DUSW_CTRL_ADDR_MSB, ctrl_sw_s};

	// Register file state
	logic [1:0] ctrl_reg, ctrl_next;
	logic [2:0] irq_status_reg, irq_status_next;
	logic [2:0] irq_mask_reg, irq_mask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wait_reg, wait_next;
	logic irq_reg, irq_next;
	logic int_reg, int_next;

	// Operation state
	dusw_state_e state_reg, state_next;
	logic [15:0] count_reg, count_next;
	logic [2:0] unit_reg, unit_next;
	logic [8:0] track_reg, track_next;
	logic wprot_reg, wprot_next;
	dusw_resp_s resp_reg, resp_next;
	logic prio_reg, prio_next;
	logic [2:0] event_set;

	logic addressed, pending, grp_protected, accept_start;
	logic [15:0] status_half;
	logic [3:0] grp_index;

	assign addressed = io_cmd.valid && (io_cmd.ctrl_addr == own_ctrl_addr) && online_s
		&& ctrl_reg[DUSW_CTRL_RESPOND_BIT];
	assign pending = (state_reg == DUSW_ST_PENDING);

	assign grp_index = io_cmd.track[8:DUSW_GROUP_LSB];
	assign grp_protected = protect_s[grp_index];
	assign accept_start = addressed && (io_cmd.code == DUSW_CMD_START) && (state_reg == DUSW_ST_IDLE)
		&& !(io_cmd.write_op && grp_protected);

	always_comb begin
		status_half = '0;
		status_half[DUSW_ST_BUSY] = (state_reg == DUSW_ST_RUN);
		status_half[DUSW_ST_PEND] = pending;
		status_half[DUSW_ST_ONLINE] = online_s;
		status_half[DUSW_ST_WPROT] = wprot_reg;
	end

	// Command handling and operation sequence
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		unit_next = unit_reg;
		track_next = track_reg;
		wprot_next = wprot_reg;
		resp_next = '0;
		event_set = '0;
		// Registered one cycle behind: a pending change reaches the chain next cycle
		prio_next = prio_in && !pending;
		if (ctrl_reg[DUSW_CTRL_CLR_UNIT_BIT]) begin
			unit_next = '0;
		end
		case (state_reg)
			DUSW_ST_IDLE: begin
			end
			DUSW_ST_RUN: begin
				if (count_reg <= 16'h0001) begin
					state_next = DUSW_ST_PENDING;
					count_next = '0;
					event_set[DUSW_IRQ_DONE_BIT] = 1'b1;
				end else begin
					count_next = count_reg - 16'h0001;
				end
			end
			DUSW_ST_PENDING: begin
			end
			default: begin
				state_next = DUSW_ST_IDLE;
			end
		endcase
		if (addressed) begin
			case (io_cmd.code)
				DUSW_CMD_START: begin
					resp_next.valid = 1'b1;
					if (accept_start) begin
						unit_next = io_cmd.unit_addr;
						track_next = io_cmd.track;
						wprot_next = 1'b0;
						count_next = io_cmd.word_count;
						state_next = DUSW_ST_RUN;
						resp_next.accepted = 1'b1;
					end else if (io_cmd.write_op && grp_protected) begin
						wprot_next = 1'b1;
						event_set[DUSW_IRQ_WPROT_BIT] = 1'b1;
					end else begin
						event_set[DUSW_IRQ_REJECT_BIT] = 1'b1;
					end
				end
				DUSW_CMD_HALT: begin
					resp_next.valid = 1'b1;
					resp_next.accepted = 1'b1;
					if (state_reg == DUSW_ST_RUN) begin
						state_next = DUSW_ST_IDLE;
						count_next = '0;
					end
				end
				DUSW_CMD_TEST_IO, DUSW_CMD_TEST_DEV: begin
					resp_next.valid = 1'b1;
					resp_next.accepted = 1'b1;
				end
				default: begin
				end
			endcase
			if (io_cmd.code != DUSW_CMD_ACK_INT && io_cmd.code != DUSW_CMD_NONE) begin
				resp_next.data[DUSW_ACK_STATUS_LSB +: 16] = status_half;
			end
		end
		if (io_cmd.valid && io_cmd.code == DUSW_CMD_ACK_INT && prio_in && pending && online_s) begin
			resp_next.valid = 1'b1;
			resp_next.accepted = 1'b1;
			resp_next.data[DUSW_ACK_STATUS_LSB +: 16] = status_half;
			resp_next.data[DUSW_ACK_UNIT_LSB +: 3] = unit_reg;
			resp_next.data[DUSW_ACK_CTRL_LSB +: 4] = own_ctrl_addr;
			state_next = DUSW_ST_IDLE;
			prio_next = 1'b0;
		end
		if (accept_start) begin
			resp_next.data[DUSW_ACK_STATUS_LSB + DUSW_ST_ACCEPT] = 1'b1;
		end
		// Own flop so the pin never shows a decode glitch
		int_next = (state_next == DUSW_ST_PENDING);
	end

	// Avalon slave: one wait cycle, then answer
	logic [7:0] reg_addr;
	logic bus_req, bus_wr;
	logic [31:0] wmask;

	assign reg_addr = {avs_address[7:2], 2'b00};
	assign bus_req = (avs_read || avs_write) && wait_reg;
	assign bus_wr = avs_write && !wait_reg;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
		{8{avs_byteenable[0]}}};

	always_comb begin
		ctrl_next = ctrl_reg;
		irq_mask_next = irq_mask_reg;
		irq_status_next = irq_status_reg;
		rdata_next = rdata_reg;
		wait_next = !bus_req;
		if (bus_wr) begin
			case (reg_addr)
				DUSW_OFS_CTRL: begin
					ctrl_next = (ctrl_reg & ~wmask[1:0]) | (avs_writedata[1:0] & wmask[1:0]);
				end
				DUSW_OFS_IRQ_MASK: begin
					irq_mask_next = (irq_mask_reg & ~wmask[2:0]) | (avs_writedata[2:0] & wmask[2:0]);
				end
				DUSW_OFS_IRQ_STATUS: begin
					irq_status_next = irq_status_reg & ~(avs_writedata[2:0] & wmask[2:0]);
				end
				default: begin
				end
			endcase
		end
		// New events win over a clear in the same cycle
		irq_status_next = irq_status_next | event_set;
		if (bus_req && avs_read) begin
			rdata_next = '0;
			case (reg_addr)
				DUSW_OFS_CTRL: rdata_next[1:0] = ctrl_reg;
				DUSW_OFS_SWITCH: begin
					rdata_next[DUSW_SW_CTRL_LSB +: 4] = own_ctrl_addr;
					rdata_next[DUSW_SW_UNIT_LSB +: 3] = unit_sw_s;
					rdata_next[DUSW_SW_ONLINE_BIT] = online_s;
					rdata_next[DUSW_SW_BUSY_BIT] = (state_reg == DUSW_ST_RUN);
					rdata_next[DUSW_SW_PEND_BIT] = pending;
				end
				DUSW_OFS_PROTECT: rdata_next[15:0] = protect_s;
				DUSW_OFS_IRQ_STATUS: rdata_next[2:0] = irq_status_reg;
				DUSW_OFS_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
				DUSW_OFS_LAST_CMD: rdata_next[15:0] = {wprot_reg, 3'h0, unit_reg, track_reg};
				default: rdata_next = '0;
			endcase
		end
		irq_next = |(irq_status_next & irq_mask_next);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= DUSW_ST_IDLE;
			count_reg <= '0;
			unit_reg <= '0;
			track_reg <= '0;
			wprot_reg <= 1'b0;
			resp_reg <= '0;
			prio_reg <= 1'b0;
			ctrl_reg <= DUSW_CTRL_RESET;
			irq_mask_reg <= DUSW_IRQ_MASK_RESET;
			irq_status_reg <= '0;
			rdata_reg <= '0;
			wait_reg <= 1'b1;
			irq_reg <= 1'b0;
			int_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			count_reg <= count_next;
			unit_reg <= unit_next;
			track_reg <= track_next;
			wprot_reg <= wprot_next;
			resp_reg <= resp_next;
			prio_reg <= prio_next;
			ctrl_reg <= ctrl_next;
			irq_mask_reg <= irq_mask_next;
			irq_status_reg <= irq_status_next;
			rdata_reg <= rdata_next;
			wait_reg <= wait_next;
			irq_reg <= irq_next;
			int_reg <= int_next;
		end
	end

	assign io_resp = resp_reg;
	assign prio_out = prio_reg;
	assign io_interrupt = int_reg;
	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign irq = irq_reg;
endmodule
`default_nettype wire

// ### testbench/dusw_top_asserts.sv
// Checker for dusw_top, bound to its ports.
// Assumes ce drops only while the ports are idle and switches stay put for several cycles.
`timescale 1ns/100ps
`default_nettype none
module dusw_top_asserts
	import dusw_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Watched ports
	input wire logic online_sw,
	input wire logic [15:0] protect_sw,
	input wire dusw_cmd_s io_cmd,
	input wire dusw_resp_s io_resp,
	input wire logic prio_in,
	input wire logic prio_out,
	input wire logic io_interrupt,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_RESP_CAUSE: assert property (io_resp.valid |-> $past(io_cmd.valid))
		else $error("answer without command");
	AST_MSB_ZERO: assert property (io_cmd.valid && io_cmd.code != DUSW_CMD_ACK_INT && !io_cmd.ctrl_addr[3]
		|=> !io_resp.valid)
		else $error("answer to address with top bit low");
	AST_OFFLINE: assert property ((!online_sw)[*6] ##0 io_cmd.valid |=> !io_resp.valid)
		else $error("answer while offline");
	AST_ACK_PRIO: assert property (io_cmd.valid && io_cmd.code == DUSW_CMD_ACK_INT && !prio_in |=> !io_resp.valid)
		else $error("ack answered without priority");
	AST_ACK_LAYOUT: assert property (io_resp.valid && $past(io_cmd.code) == DUSW_CMD_ACK_INT
		|-> io_resp.data[31:27] == 5'h01)
		else $error("ack address field wrong");
	AST_PROT_REFUSE: assert property ($stable(protect_sw)[*6] ##0 (io_cmd.valid
		&& io_cmd.code == DUSW_CMD_START && io_cmd.write_op && protect_sw[io_cmd.track[8:5]])
		|=> !(io_resp.valid && io_resp.accepted))
		else $error("write to protected group accepted");
	AST_INT_DROP: assert property (io_resp.valid && $past(io_cmd.code) == DUSW_CMD_ACK_INT |-> !io_interrupt)
		else $error("interrupt held after ack");
	AST_PRIO_BLOCK: assert property (!prio_in |=> !prio_out)
		else $error("priority passed on without input");
	AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
endmodule
bind dusw_top dusw_top_asserts u_dusw_top_asserts (.core_clk(core_clk), .reset(reset), .online_sw(online_sw),
	.protect_sw(protect_sw), .io_cmd(io_cmd), .io_resp(io_resp), .prio_in(prio_in), .prio_out(prio_out),
	.io_interrupt(io_interrupt), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// ### testbench/dusw_iop_model.sv
// Behavioural io_processor: turns a bench request into a one-cycle command.
// Assumes the bench raises req.valid for one cycle per command.
`timescale 1ns/100ps
`default_nettype none
module dusw_iop_model
	import dusw_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Request in, command out
	input wire dusw_cmd_s req,
	output var dusw_cmd_s io_cmd
);
	// one-shot command
	// Idle fields flip every cycle so a stale value never passes for a live one
	always_ff @(posedge core_clk) begin
		if (reset) begin
			io_cmd <= '0;
		end else if (req.valid) begin
			io_cmd <= req;
		end else begin
			io_cmd <= {1'b0, ~io_cmd[$bits(dusw_cmd_s)-2:0]};
		end
	end
endmodule
`default_nettype wire

// ### testbench/dusw_top_test.sv
// Self-checking bench for dusw_top: command rows, then bus, interrupt and offline cases.
// Assumes dusw_iop_model sits between the bench and the command port.
`timescale 1ns/100ps
`default_nettype none
module dusw_top_test;
	import dusw_pkg::*;
	typedef struct packed {
		dusw_cmd_e c;
		logic [3:0] a;
		logic [8:0] t;
		logic w;
		logic rv;
		logic ra;
	} dusw_row_s;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] unit_addr_sw = 3'h2;
	logic [2:0] ctrl_addr_sw = 3'h5;
	logic ce = 1'b1;
	logic online_sw = 1'b1;
	logic [15:0] protect_sw = 16'h8001;
	logic prio_in = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	dusw_cmd_s next_cmd = '0;
	dusw_cmd_s io_cmd;
	dusw_resp_s io_resp, rsp;
	logic prio_out, io_interrupt, irq, avs_waitrequest, got;
	logic [31:0] avs_readdata, rdata;
	int fail_count = 0;
	int total_checks = 0;
	int cyc = 0;
	// First busy start is halted before the next start, the start after that is refused while busy; protected groups are 0 and 15
	dusw_row_s rows [12] = '{
		'{DUSW_CMD_TEST_IO, 4'hD, 9'h000, 1'b0, 1'b1, 1'b0},
		'{DUSW_CMD_TEST_DEV, 4'hD, 9'h000, 1'b0, 1'b1, 1'b0},
		'{DUSW_CMD_HALT, 4'hD, 9'h000, 1'b0, 1'b1, 1'b0},
		'{DUSW_CMD_TEST_IO, 4'hC, 9'h000, 1'b0, 1'b0, 1'b0},
		'{DUSW_CMD_TEST_IO, 4'h5, 9'h000, 1'b0, 1'b0, 1'b0},
		'{DUSW_CMD_START, 4'hD, 9'h01F, 1'b1, 1'b1, 1'b0},
		'{DUSW_CMD_START, 4'hD, 9'h1E0, 1'b1, 1'b1, 1'b0},
		'{DUSW_CMD_START, 4'hD, 9'h000, 1'b0, 1'b1, 1'b1},
		'{DUSW_CMD_HALT, 4'hD, 9'h000, 1'b0, 1'b1, 1'b0},
		'{DUSW_CMD_START, 4'hD, 9'h020, 1'b1, 1'b1, 1'b1},
		'{DUSW_CMD_START, 4'hD, 9'h020, 1'b1, 1'b1, 1'b0},
		'{DUSW_CMD_HALT, 4'hD, 9'h000, 1'b0, 1'b1, 1'b0}};
	dusw_iop_model u_dusw_iop_model (.core_clk(core_clk), .reset(reset), .req(next_cmd), .io_cmd(io_cmd));
	dusw_top u_dusw_top (.core_clk(core_clk), .reset(reset), .ce(ce), .ctrl_addr_sw(ctrl_addr_sw),
		.unit_addr_sw(unit_addr_sw), .online_sw(online_sw), .protect_sw(protect_sw), .io_cmd(io_cmd),
		.io_resp(io_resp), .prio_in(prio_in), .prio_out(prio_out), .io_interrupt(io_interrupt),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk(k < 20, 1, "bus answer");
	endtask
	task automatic cmd(input dusw_cmd_e c, input logic [3:0] a, input logic [2:0] u, input logic [8:0] t,
		input logic w, input logic [15:0] n);
		@(posedge core_clk);
		next_cmd <= '{1'b1, c, a, u, t, w, n};
		@(posedge core_clk);
		next_cmd.valid <= 1'b0;
		got = 1'b0;
		repeat (4) begin
			@(posedge core_clk);
			if (io_resp.valid === 1'b1) begin
				got = 1'b1;
				rsp = io_resp;
			end
		end
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	initial begin
		int k;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk(io_resp.valid, 0, "resp after reset");
		chk(avs_waitrequest, 1, "wait after reset");
		bus(1'b0, DUSW_OFS_CTRL, 32'h0);
		chk(rdata, 32'h1, "ctrl reset");
		bus(1'b0, DUSW_OFS_IRQ_MASK, 32'h0);
		chk(rdata, 32'h0, "mask reset");
		$display("test reset done");
		foreach (rows[i]) begin
			cmd(rows[i].c, rows[i].a, 3'h0, rows[i].t, rows[i].w, 16'h0100);
			chk(got, rows[i].rv, "row answer");
			if (rows[i].c == DUSW_CMD_START) chk(rsp.accepted, rows[i].ra, "row accept");
		end
		$display("test rows done");
		bus(1'b1, DUSW_OFS_IRQ_STATUS, 32'h7);
		cmd(DUSW_CMD_START, 4'hD, 3'h6, 9'h100, 1'b1, 16'h0003);
		chk(rsp.accepted, 1, "start accepted");
		k = 0;
		while (io_interrupt !== 1'b1 && k < 40) begin
			@(posedge core_clk);
			k++;
		end
		chk(io_interrupt, 1, "done interrupt");
		bus(1'b0, DUSW_OFS_IRQ_STATUS, 32'h0);
		chk(rdata, 32'h1, "done status");
		chk(irq, 0, "irq masked");
		bus(1'b1, DUSW_OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge core_clk);
		chk(irq, 1, "irq raised");
		cmd(DUSW_CMD_ACK_INT, 4'h0, 3'h0, 9'h000, 1'b0, 16'h0000);
		chk(got, 0, "ack without priority");
		prio_in <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk(prio_out, 0, "prio held while pending");
		cmd(DUSW_CMD_ACK_INT, 4'h0, 3'h0, 9'h000, 1'b0, 16'h0000);
		chk(got, 1, "ack answer");
		chk(rsp.data[31:21], {4'h0, 4'hD, 3'h6}, "ack address");
		chk(rsp.data[2], 1, "ack online status");
		chk(io_interrupt, 0, "ack clears");
		chk(prio_out, 1, "prio passed on");
		bus(1'b1, DUSW_OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge core_clk);
		chk(irq, 0, "irq cleared");
		$display("test interrupt done");
		// Freeze mid-run while the ports are idle: the count must not move
		cmd(DUSW_CMD_START, 4'hD, 3'h1, 9'h040, 1'b0, 16'h0008);
		chk(rsp.accepted, 1, "second start accepted");
		ce <= 1'b0;
		repeat (20) @(posedge core_clk);
		chk(io_interrupt, 0, "frozen run");
		ce <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk(io_interrupt, 1, "run resumes");
		bus(1'b0, DUSW_OFS_LAST_CMD, 32'h0);
		chk(rdata, 32'h240, "last command");
		cmd(DUSW_CMD_ACK_INT, 4'h0, 3'h0, 9'h000, 1'b0, 16'h0000);
		chk(got, 1, "second ack answer");
		chk(rsp.data[23:21], 3'h1, "ack unit after freeze");
		$display("test freeze done");
		bus(1'b0, DUSW_OFS_SWITCH, 32'h0);
		chk(rdata[7:0], 8'hAD, "switch readback");
		bus(1'b0, DUSW_OFS_PROTECT, 32'h0);
		chk(rdata, 32'h8001, "protect readback");
		bus(1'b0, 8'h3C, 32'h0);
		chk(rdata, 32'h0, "unmapped read");
		ctrl_addr_sw <= 3'h0;
		repeat (6) @(posedge core_clk);
		cmd(DUSW_CMD_TEST_IO, 4'h8, 3'h0, 9'h000, 1'b0, 16'h0000);
		chk(got, 1, "address 1000 answer");
		cmd(DUSW_CMD_TEST_IO, 4'hD, 3'h0, 9'h000, 1'b0, 16'h0000);
		chk(got, 0, "old address ignored");
		ctrl_addr_sw <= 3'h5;
		online_sw <= 1'b0;
		repeat (6) @(posedge core_clk);
		cmd(DUSW_CMD_TEST_IO, 4'hD, 3'h0, 9'h000, 1'b0, 16'h0000);
		chk(got, 0, "offline answer");
		bus(1'b0, DUSW_OFS_SWITCH, 32'h0);
		chk(rdata[7], 0, "offline readback");
		$display("test offline done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
